// ===== rtcb_asserts.sv
// Port-level assertions for the real-time clock block
`timescale 1ns/10ps
`include "rtcb_defs.svh"
module rtcb_asserts (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // Sources
  input wire logic        lse_tick,
  input wire logic        lsi_tick,
  input wire logic        hse_tick,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // Outputs
  input wire logic        irq_sec,
  input wire logic        irq_alarm,
  input wire logic        cal_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire any_tk = lse_tick | lsi_tick | hse_tick;
  wire st_wr  = wr && addr == `RTCB_OFS_STAT;
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  a_out_reset: assert property ($rose(rstn) |-> !irq_sec && !irq_alarm)
    else $error("interrupt high after reset");
  a_sec_hold: assert property (irq_sec && !(st_wr && wdata[0]) |=> irq_sec)
    else $error("periodic flag dropped");
  a_sec_clear: assert property (irq_sec && st_wr && wdata[0] && !any_tk
    |=> !irq_sec)
    else $error("periodic flag not cleared");
  a_sec_cause: assert property ($rose(irq_sec) |-> $past(any_tk))
    else $error("periodic flag without source tick");
  a_alarm_hold: assert property (irq_alarm && !(st_wr && wdata[1])
    |=> irq_alarm)
    else $error("alarm flag dropped");
  a_alarm_tick: assert property ($rose(irq_alarm) |-> irq_sec)
    else $error("alarm off the time base");
  a_cal_cause: assert property ($changed(cal_out)
    |-> $past(any_tk, 2) || $past(wr, 2))
    else $error("calibration output moved without tick");
endmodule
bind rtcb_top rtcb_asserts u_chk (.ref_clk(ref_clk), .rstn(rstn),
  .lse_tick(lse_tick), .lsi_tick(lsi_tick), .hse_tick(hse_tick),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .irq_sec(irq_sec), .irq_alarm(irq_alarm), .cal_out(cal_out));

// ===== rtcb_bkp_mem.sv
// Backup data store: ten 16-bit words with registered read data
`timescale 1ns/10ps
module rtcb_bkp_mem #(
  parameter int WORDS = 10,
  parameter int AW    = 4
) (
  // Clock
  input  wire logic          ref_clk,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [15:0]   wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [15:0]   rdata
);
  logic [15:0] mem [WORDS];

  // No reset: contents must survive a reset of the logic around it
  always_ff @(posedge ref_clk) begin
    if (we && (waddr < AW'(WORDS))) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (raddr < AW'(WORDS)) begin
      rdata <= mem[raddr];
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule

// ===== rtcb_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RTCB_DEFS_SVH
`define RTCB_DEFS_SVH
`define RTCB_OFS_CTRL     8'h00
`define RTCB_OFS_STAT     8'h04
`define RTCB_OFS_PRE_LD   8'h08
`define RTCB_OFS_PRE_CNT  8'h0C
`define RTCB_OFS_CNT      8'h10
`define RTCB_OFS_CMP      8'h14
`define RTCB_OFS_BKP0     8'h20
`define RTCB_BKP_NUM      10
`define RTCB_PRE_RESET    20'h07FFF
`define RTCB_CMP_RESET    32'hFFFFFFFF
`define RTCB_HSE_DIV      128
`define RTCB_CAL_DIV      64
`define RTCB_CTRL_EN      0
`define RTCB_CTRL_SRC_LO  1
`define RTCB_CTRL_SRC_HI  2
`define RTCB_CTRL_CAL     3
`define RTCB_STAT_SEC     0
`define RTCB_STAT_ALR     1
`endif

// ===== rtcb_pkg.sv
// Types shared by the real-time clock block
package rtcb_pkg;
  typedef enum logic [1:0] {
    RTCB_SRC_LSE = 2'b00,
    RTCB_SRC_LSI = 2'b01,
    RTCB_SRC_HSE = 2'b10
  } rtcb_src_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rtcb_req_t;
endpackage

// ===== rtcb_top.sv
// Real-time clock: source select, prescaler, counter, alarm, backup store
`timescale 1ns/10ps
`include "rtcb_defs.svh"
module rtcb_top
  import rtcb_pkg::*;
#(
  parameter int PRE_W = 20,
  parameter int CNT_W = 32
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Time base sources, synchronous one-cycle-wide edge strobes
  input  wire logic        lse_tick,
  input  wire logic        lsi_tick,
  input  wire logic        hse_tick,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Interrupts and calibration
  output logic             irq_sec,
  output logic             irq_alarm,
  output logic             cal_out
);
  rtcb_req_t             req;
  logic                  enable;
  rtcb_src_t             src;
  logic                  cal_en;
  logic [6:0]            hse_div;
  logic                  tb_tick;
  logic [PRE_W-1:0]      pre_load;
  logic [PRE_W-1:0]      pre_cnt;
  logic [CNT_W-1:0]      cnt;
  logic [CNT_W-1:0]      cmp;
  logic                  sec_tick;
  logic                  sec_flag;
  logic                  alr_flag;
  logic [5:0]            cal_div;
  logic                  rd_q;
  logic [31:0]           reg_rdata;
  logic                  bkp_sel_q;
  logic [15:0]           bkp_rdata;
  logic                  bkp_we;
  logic [3:0]            bkp_idx;
  logic [7:0]            bkp_ofs;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  function automatic logic is_bkp(input logic [7:0] a);
    is_bkp = (a >= `RTCB_OFS_BKP0) &&
             (a < (`RTCB_OFS_BKP0 + 8'(4 * `RTCB_BKP_NUM))) &&
             (a[1:0] == 2'b00);
  endfunction

  function automatic logic wr_hit(input rtcb_req_t r,
                                  input logic [7:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction

  assign bkp_ofs = req.addr - `RTCB_OFS_BKP0;
  assign bkp_idx = bkp_ofs[5:2];
  assign bkp_we  = req.wr && is_bkp(req.addr);

  // Control register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      enable <= 1'b0;
      src    <= RTCB_SRC_LSE;
      cal_en <= 1'b0;
    end else if (wr_hit(req, `RTCB_OFS_CTRL)) begin
      enable <= req.wdata[`RTCB_CTRL_EN];
      src    <= rtcb_src_t'(req.wdata[`RTCB_CTRL_SRC_HI:`RTCB_CTRL_SRC_LO]);
      cal_en <= req.wdata[`RTCB_CTRL_CAL];
    end
  end

  // HSE divided by 128
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      hse_div <= 7'h00;
    end else if (hse_tick) begin
      hse_div <= hse_div + 7'h01;
    end
  end

  // Source select; an illegal code stops the time base
  always_comb begin
    unique case (src)
      RTCB_SRC_LSE: tb_tick = lse_tick;
      RTCB_SRC_LSI: tb_tick = lsi_tick;
      RTCB_SRC_HSE: tb_tick = hse_tick && (hse_div == 7'h7F);
      default:      tb_tick = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pre_load <= PRE_W'(`RTCB_PRE_RESET);
    end else if (wr_hit(req, `RTCB_OFS_PRE_LD)) begin
      pre_load <= req.wdata[PRE_W-1:0];
    end
  end

  // Prescaler counts down, reloading on wrap; a reload write restarts it
  assign sec_tick = enable && tb_tick && (pre_cnt == '0);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pre_cnt <= PRE_W'(`RTCB_PRE_RESET);
    end else if (wr_hit(req, `RTCB_OFS_PRE_LD)) begin
      pre_cnt <= req.wdata[PRE_W-1:0];
    end else if (enable && tb_tick) begin
      if (pre_cnt == '0) begin
        pre_cnt <= pre_load;
      end else begin
        pre_cnt <= pre_cnt - PRE_W'(1);
      end
    end
  end

  // Counter: a software load wins over a tick in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt <= '0;
    end else if (wr_hit(req, `RTCB_OFS_CNT)) begin
      cnt <= req.wdata[CNT_W-1:0];
    end else if (sec_tick) begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cmp <= CNT_W'(`RTCB_CMP_RESET);
    end else if (wr_hit(req, `RTCB_OFS_CMP)) begin
      cmp <= req.wdata[CNT_W-1:0];
    end
  end

  // Sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sec_flag <= 1'b0;
    end else if (sec_tick) begin
      sec_flag <= 1'b1;
    end else if (wr_hit(req, `RTCB_OFS_STAT) &&
                 req.wdata[`RTCB_STAT_SEC]) begin
      sec_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      alr_flag <= 1'b0;
    end else if (enable && (cnt == cmp) && sec_tick) begin
      alr_flag <= 1'b1;
    end else if (wr_hit(req, `RTCB_OFS_STAT) &&
                 req.wdata[`RTCB_STAT_ALR]) begin
      alr_flag <= 1'b0;
    end
  end

  assign irq_sec   = sec_flag;
  assign irq_alarm = alr_flag;

  // 32768 / 64 = 512 Hz: toggle every 32 source edges
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cal_div <= 6'h00;
    end else if (cal_en && tb_tick) begin
      cal_div <= cal_div + 6'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cal_out <= 1'b0;
    end else begin
      cal_out <= cal_en && cal_div[5];
    end
  end

  rtcb_bkp_mem #(
    .WORDS (`RTCB_BKP_NUM),
    .AW    (4)
  ) u_bkp (
    .ref_clk (ref_clk),
    .we      (bkp_we),
    .waddr   (bkp_idx),
    .wdata   (req.wdata[15:0]),
    .raddr   (bkp_idx),
    .rdata   (bkp_rdata)
  );

  // Read path: address captured with the strobe, data valid next cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rd_q      <= 1'b0;
      bkp_sel_q <= 1'b0;
      reg_rdata <= 32'h00000000;
    end else begin
      rd_q      <= req.rd;
      bkp_sel_q <= is_bkp(req.addr);
      unique case (req.addr)
        `RTCB_OFS_CTRL:    reg_rdata <= {28'h0000000, cal_en, src, enable};
        `RTCB_OFS_STAT:    reg_rdata <= {30'h00000000, alr_flag, sec_flag};
        `RTCB_OFS_PRE_LD:  reg_rdata <= 32'(pre_load);
        `RTCB_OFS_PRE_CNT: reg_rdata <= 32'(pre_cnt);
        `RTCB_OFS_CNT:     reg_rdata <= 32'(cnt);
        `RTCB_OFS_CMP:     reg_rdata <= 32'(cmp);
        default:           reg_rdata <= 32'h00000000;
      endcase
    end
  end

  always_comb begin
    if (!rd_q) begin
      rdata = 32'h00000000;
    end else if (bkp_sel_q) begin
      rdata = {16'h0000, bkp_rdata};
    end else begin
      rdata = reg_rdata;
    end
  end
endmodule

// ===== tb.sv
// Self-checking testbench for the real-time clock block
`timescale 1ns/10ps
`include "rtcb_defs.svh"
module tb;
  logic        ref_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic [2:0]  tk      = 3'h0;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [31:0] rdata;
  logic        irq_sec, irq_alarm, cal_out;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          tog;
  logic        last;
  always #12.5 ref_clk = ~ref_clk;
  rtcb_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .lse_tick(tk[0]),
    .lsi_tick(tk[1]), .hse_tick(tk[2]), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq_sec(irq_sec),
    .irq_alarm(irq_alarm), .cal_out(cal_out));
  task automatic finish_test;
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run needs about 1600 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input string w, input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(w, e, rdata);
  endtask
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      tk[k] <= 1'b1;
      @(posedge ref_clk);
      tk[k] <= 1'b0;
    end
  endtask
  task automatic t_reset;
    rreg("cmp", `RTCB_OFS_CMP, 32'hFFFFFFFF);
    rreg("reload", `RTCB_OFS_PRE_LD, 32'h00007FFF);
    rreg("unmapped", 8'hFC, 32'h0);
  endtask
  task automatic t_backup;
    for (int i = 0; i < 10; i++) wreg(`RTCB_OFS_BKP0 + 8'(4 * i),
      32'hA5A50000 | 32'(i * 16'h1111));
    for (int i = 0; i < 10; i++) rreg("backup", `RTCB_OFS_BKP0 + 8'(4 * i),
      32'(i * 16'h1111));
  endtask
  // Backup words must survive a reset of the logic around them
  task automatic t_retain;
    wreg(`RTCB_OFS_CNT, 32'h00001234);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    rreg("kept backup", `RTCB_OFS_BKP0 + 8'h0C, 32'h00003333);
    rreg("reset count", `RTCB_OFS_CNT, 32'h0);
  endtask
  // Other sources are pulsed first and must not advance the count
  task automatic t_sources;
    for (int s = 0; s < 3; s++) begin
      wreg(`RTCB_OFS_PRE_LD, 32'h3);
      wreg(`RTCB_OFS_CNT, 32'h0);
      wreg(`RTCB_OFS_CTRL, 32'(s * 2 + 1));
      rreg("pre count", `RTCB_OFS_PRE_CNT, 32'h3);
      pulse((s + 1) % 3, 4);
      pulse((s + 2) % 3, 4);
      rreg("held count", `RTCB_OFS_CNT, 32'h0);
      pulse(s, s == 2 ? 4 * `RTCB_HSE_DIV : 4);
      rreg("count", `RTCB_OFS_CNT, 32'h1);
      chk("irq_sec", 32'h1, 32'(irq_sec));
      wreg(`RTCB_OFS_STAT, 32'h1);
      #1 chk("irq_sec", 32'h0, 32'(irq_sec));
    end
    // Source code 3 selects nothing, so even a zero reload must not count
    wreg(`RTCB_OFS_CTRL, 32'h7);
    wreg(`RTCB_OFS_PRE_LD, 32'h0);
    pulse(0, 2);
    pulse(1, 2);
    rreg("stopped count", `RTCB_OFS_CNT, 32'h1);
  endtask
  task automatic t_alarm;
    wreg(`RTCB_OFS_CTRL, 32'h1);
    wreg(`RTCB_OFS_PRE_LD, 32'h3);
    wreg(`RTCB_OFS_CNT, 32'h5);
    wreg(`RTCB_OFS_CMP, 32'h5);
    pulse(0, 4);
    #1 chk("irq_alarm", 32'h1, 32'(irq_alarm));
    rreg("stat", `RTCB_OFS_STAT, 32'h3);
    wreg(`RTCB_OFS_STAT, 32'h2);
    #1 chk("irq_alarm", 32'h0, 32'(irq_alarm));
    rreg("count", `RTCB_OFS_CNT, 32'h6);
  endtask
  // Two full periods give four edges whatever the starting phase
  task automatic t_cal;
    wreg(`RTCB_OFS_CTRL, 32'h9);
    tog = 0;
    last = cal_out;
    repeat (2 * `RTCB_CAL_DIV) begin
      pulse(0, 1);
      // The output is registered once more after the divider moves
      @(posedge ref_clk);
      #1 if (cal_out !== last) tog++;
      last = cal_out;
    end
    chk("cal edges", 32'h4, 32'(tog));
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset;
    t_backup;
    t_retain;
    t_sources;
    t_alarm;
    t_cal;
    finish_test;
  end
endmodule
